// ==== sim/sbsc_core_bench.sv ====
// Self-checking bench for the burst memory core
`timescale 1ns/1ps
`default_nettype none
`include "sbsc_defines.svh"
module sbsc_core_bench;
   typedef struct packed {
      logic [1:0]          wn;
      logic [1:0]          ln;
      logic [2:0]          a;
      logic [`SBSC_DW-1:0] d;
   } sbsc_row_t;
   logic clk, nrst, sel_n, cpu_strobe_n, ctrl_strobe_n, burst_step_n, all_write_n;
   logic lane_write_n, out_en_n, sleep_req, linear_order_n, bypass_mode_n, dq_oe, asleep;
   logic single_deselect_sel, ninth_bit_en_n, parity_odd;
   logic [`SBSC_AW-1:0]    addr;
   logic [`SBSC_DW-1:0]    dq_in, dq_out;
   logic [`SBSC_LANES-1:0] lane_enable_n, parity_err;
   logic [2:0]             mode_driven;
   logic [`SBSC_DW-1:0]    m [4];
   sbsc_row_t              r;
   int                     i, k, l, lo, num_errors = 0, checked = 0;
   sbsc_row_t rows [8] = '{'{2'h2, 2'h3, 3'h4, 18'h0aaaa}, '{2'h2, 2'h3, 3'h5, 18'h15555},
      '{2'h0, 2'h3, 3'h6, 18'h01234}, '{2'h2, 2'h3, 3'h7, 18'h3c3c3},
      '{2'h1, 2'h2, 3'h4, 18'h3ffff}, '{2'h1, 2'h1, 3'h5, 18'h00000},
      '{2'h1, 2'h3, 3'h6, 18'h3ffff}, '{2'h3, 2'h0, 3'h7, 18'h00000}};

   sbsc_core dut (.clk, .nrst, .addr, .dq_in, .dq_out, .dq_oe, .chip_sel1_n(sel_n),
      .chip_sel2(!sel_n), .chip_sel3_n(sel_n), .cpu_strobe_n, .ctrl_strobe_n, .burst_step_n,
      .all_write_n, .lane_write_n, .lane_enable_n, .out_en_n, .sleep_req, .linear_order_n,
      .bypass_mode_n, .single_deselect_sel, .mode_driven, .ninth_bit_en_n, .parity_odd,
      .parity_err, .asleep);
   sbsc_ctl_model ctl (.clk, .addr, .dq_in, .sel_n, .cpu_strobe_n, .ctrl_strobe_n,
      .burst_step_n, .all_write_n, .lane_write_n, .lane_enable_n);

   initial begin
      clk = 0;
      forever #12.5 clk = ~clk;
   end

   task automatic results;
      if (num_errors == 0 && checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   task automatic chk(input string n, input logic [`SBSC_DW-1:0] e,
                      input logic [`SBSC_DW-1:0] v);
      checked++;
      if (v !== e) begin
         $display("wrong value %s expected %h seen %h", n, e, v);
         num_errors++;
      end
   endtask

   task automatic rd(input logic [`SBSC_DW-1:0] e);
      chk("dq_oe", 1, dq_oe);
      chk("dq_out", e, dq_out);
   endtask

   task automatic go(input logic [1:0] s, input int a, input logic st);
      ctl.op(s, 2'h3, 2'h3, a[`SBSC_AW-1:0], '0, st);
   endtask

   initial begin
      #100000;
      num_errors++;
      results;
   end

   initial begin
      nrst = 0; out_en_n = 0; sleep_req = 0; linear_order_n = 0; bypass_mode_n = 0;
      single_deselect_sel = 1; mode_driven = 3'h7; ninth_bit_en_n = 1; parity_odd = 0;
      repeat (4) @(posedge clk);
      #2;
      nrst = 1;
      chk("dq_oe", 0, dq_oe);
      chk("parity_err", 0, parity_err);
      chk("asleep", 0, asleep);
      foreach (rows[i]) begin
         r = rows[i];
         ctl.op(i[0] ? 2'h2 : 2'h1, r.wn, r.ln, {16'h0, r.a}, r.d, 1'b1);
         for (l = 0; l < 2; l++)
            if (!r.wn[0] || (!r.wn[1] && !r.ln[l])) m[r.a[1:0]][9*l +: 9] = r.d[9*l +: 9];
      end
      for (k = 4; k < 8; k++) begin
         go(2'h1, k, 1'b1);
         rd(m[k & 3]);
      end
      for (lo = 0; lo < 2; lo++) begin
         linear_order_n = lo[0];
         for (i = 0; i < 6; i++) begin
            k = (i == 5) ? 4 : i;
            go(i == 0 ? 2'h2 : 2'h0, 5, i == 0 || i == 5);
            rd(m[lo ? ((1 ^ k) & 3) : ((1 + k) & 3)]);
         end
         go(2'h3, 5, 1'b1);
      end
      bypass_mode_n = 1;
      for (lo = 0; lo < 2; lo++) begin
         single_deselect_sel = !lo[0];
         go(2'h1, 4, 1'b1);
         chk("dq_oe", 0, dq_oe);
         go(2'h0, 4, 1'b0);
         rd(m[0]);
         go(2'h3, 4, 1'b1);
         if (lo) rd(m[1]);
         else chk("dq_oe", 0, dq_oe);
         go(2'h0, 4, 1'b1);
         chk("dq_oe", 0, dq_oe);
      end
      // Pins set the other way but left undriven must lose to the floating defaults
      mode_driven = 3'h0;
      bypass_mode_n = 0; linear_order_n = 0; single_deselect_sel = 0;
      go(2'h1, 5, 1'b1);
      go(2'h0, 5, 1'b0);
      rd(m[1]);
      go(2'h0, 5, 1'b0);
      rd(m[0]);
      go(2'h3, 5, 1'b1);
      chk("dq_oe", 0, dq_oe);
      go(2'h0, 5, 1'b1);
      mode_driven = 3'h7;
      go(2'h1, 6, 1'b1);
      rd(m[2]);
      out_en_n = 1;
      #1 chk("dq_oe", 0, dq_oe);
      out_en_n = 0;
      sleep_req = 1;
      #1 chk("dq_oe", 0, dq_oe);
      @(posedge clk);
      #2;
      chk("asleep", 1, asleep);
      ctl.op(2'h1, 2'h2, 2'h3, 19'h6, 18'h0, 1'b1);
      sleep_req = 0;
      go(2'h1, 6, 1'b1);
      rd(m[2]);
      ninth_bit_en_n = 0;
      ctl.op(2'h1, 2'h2, 2'h3, 19'h8, 18'h00200, 1'b1);
      go(2'h2, 8, 1'b1);
      go(2'h0, 8, 1'b1);
      chk("parity_err", 2'h2, parity_err);
      parity_odd = 1;
      go(2'h3, 8, 1'b1);
      chk("parity_err", 2'h1, parity_err);
      results;
   end
endmodule
`default_nettype wire

// ==== sim/sbsc_ctl_model.sv ====
// Controller model that drives the memory core pins cycle by cycle
`timescale 1ns/1ps
`default_nettype none
`include "sbsc_defines.svh"
module sbsc_ctl_model (
   input  wire logic                   clk,
   output var  logic [`SBSC_AW-1:0]    addr,
   output var  logic [`SBSC_DW-1:0]    dq_in,
   output var  logic                   sel_n,
   output var  logic                   cpu_strobe_n,
   output var  logic                   ctrl_strobe_n,
   output var  logic                   burst_step_n,
   output var  logic                   all_write_n,
   output var  logic                   lane_write_n,
   output var  logic [`SBSC_LANES-1:0] lane_enable_n
);
   initial begin
      {cpu_strobe_n, ctrl_strobe_n, sel_n, burst_step_n} = 4'hf;
      {all_write_n, lane_write_n} = 2'h3;
      lane_enable_n = 2'h3;
      addr = '0;
      dq_in = '0;
   end

   // s: 0 none, 1 cpu strobe, 2 controller strobe, 3 strobe while unselected
   task automatic op(input logic [1:0] s, input logic [1:0] wn, input logic [1:0] ln,
                     input logic [`SBSC_AW-1:0] a, input logic [`SBSC_DW-1:0] d,
                     input logic st);
      cpu_strobe_n = s != 2'h1;
      ctrl_strobe_n = s < 2'h2;
      sel_n = s == 2'h3;
      {lane_write_n, all_write_n} = wn;
      lane_enable_n = ln;
      burst_step_n = st;
      addr = a;
      // Idle data lines flip so a stale value never looks valid
      dq_in = (wn != 2'h3) ? d : ~dq_in;
      @(posedge clk);
      #2;
   endtask
endmodule
`default_nettype wire

// ==== verilog/sbsc_burst.sv ====
// Two-bit burst address counter
`timescale 1ns/1ps
`default_nettype none
`include "sbsc_defines.svh"
module sbsc_burst
   import sbsc_pkg::*;
(
   input  wire logic      clk,
   input  wire logic      nrst,
   input  wire logic      load,
   input  wire logic      step,
   input  wire sbsc_low_t start_in,
   input  wire logic      linear,
   output var  sbsc_low_t cur_low,
   output var  sbsc_low_t step_low
);
   sbsc_low_t start;
   sbsc_low_t cnt;

   always_ff @(posedge clk) begin
      if (!nrst) begin
         start <= 2'h0;
         cnt   <= 2'h0;
      end else if (load) begin
         start <= start_in;
         cnt   <= 2'h0;
      end else if (step) begin
         cnt <= cnt + 2'h1;
      end
   end

   always_comb begin
      cur_low  = sbsc_seq(start, cnt, linear);
      step_low = sbsc_seq(start, sbsc_low_t'(cnt + 2'h1), linear);
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   wrap_four_a: assert property (
      (step && !load) [*4] |=> (cur_low == $past(cur_low, 4)))
      else $error("burst does not wrap after four steps");
endmodule
`default_nettype wire

// ==== verilog/sbsc_core.sv ====
// Synchronous burst static memory core top level
`timescale 1ns/1ps
`default_nettype none
`include "sbsc_defines.svh"
module sbsc_core
   import sbsc_pkg::*;
(
   input  wire logic                   clk,
   input  wire logic                   nrst,
   input  wire logic [`SBSC_AW-1:0]    addr,
   input  wire logic [`SBSC_DW-1:0]    dq_in,
   output var  logic [`SBSC_DW-1:0]    dq_out,
   output var  logic                   dq_oe,
   input  wire logic                   chip_sel1_n,
   input  wire logic                   chip_sel2,
   input  wire logic                   chip_sel3_n,
   input  wire logic                   cpu_strobe_n,
   input  wire logic                   ctrl_strobe_n,
   input  wire logic                   burst_step_n,
   input  wire logic                   all_write_n,
   input  wire logic                   lane_write_n,
   input  wire logic [`SBSC_LANES-1:0] lane_enable_n,
   input  wire logic                   out_en_n,
   input  wire logic                   sleep_req,
   input  wire logic                   linear_order_n,
   input  wire logic                   bypass_mode_n,
   input  wire logic                   single_deselect_sel,
   input  wire logic [2:0]             mode_driven,
   input  wire logic                   ninth_bit_en_n,
   input  wire logic                   parity_odd,
   output var  logic [`SBSC_LANES-1:0] parity_err,
   output var  logic                   asleep
);
   sbsc_state_t              state;
   logic                     selected;
   logic                     strobe;
   logic                     awake;
   logic                     load;
   logic                     desel;
   logic                     cont;
   logic                     step;
   logic                     access;
   logic                     rd;
   logic [`SBSC_LANES-1:0]   wmask;
   logic [`SBSC_AW-3:0]      addr_hi;
   logic [`SBSC_AW-1:0]      mem_addr;
   sbsc_low_t                cur_low;
   sbsc_low_t                step_low;
   logic [`SBSC_DW-1:0]      mem_rdata;
   logic [`SBSC_DW-1:0]      pipe_data;
   logic                     rd_v1;
   logic                     rd_v2;
   logic                     desel_v1;
   logic                     dq_en;
   logic                     next_dq_en;
   logic                     pipelined;
   logic                     linear;
   logic                     two_cycle_deselect;

   // Undriven mode pins fall back to the internal pull defaults
   always_comb begin
      pipelined = mode_driven[`SBSC_MD_BYPASS] ? bypass_mode_n : 1'b1;
      linear    = mode_driven[`SBSC_MD_ORDER] ? !linear_order_n : 1'b0;
      two_cycle_deselect =
         mode_driven[`SBSC_MD_DESEL] ? !single_deselect_sel : 1'b0;
   end

   // Cycle decode; sleep gates it without any clock
   always_comb begin
      selected = !chip_sel1_n && chip_sel2 && !chip_sel3_n;
      strobe   = !cpu_strobe_n || !ctrl_strobe_n;
      awake    = !sleep_req;
      load     = awake && strobe && selected;
      desel    = awake && strobe && !selected;
      cont     = awake && !strobe && (state == SBSC_BURST);
      step     = cont && !burst_step_n;
      access   = load || cont;
   end

   // Global write beats the byte write qualifier
   always_comb begin
      if (!access) begin
         wmask = '0;
      end else if (!all_write_n) begin
         wmask = '1;
      end else if (!lane_write_n) begin
         wmask = ~lane_enable_n;
      end else begin
         wmask = '0;
      end
      rd = access && (wmask == '0);
   end

   always_comb begin
      if (load) begin
         mem_addr = addr;
      end else begin
         mem_addr = {addr_hi, step ? step_low : cur_low};
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         state <= SBSC_IDLE;
      end else if (load) begin
         state <= SBSC_BURST;
      end else if (desel) begin
         state <= SBSC_IDLE;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         addr_hi <= '0;
      end else if (load) begin
         addr_hi <= addr[`SBSC_AW-1:2];
      end
   end

   sbsc_burst u_burst (
      .clk      (clk),
      .nrst     (nrst),
      .load     (load),
      .step     (step),
      .start_in (addr[1:0]),
      .linear   (linear),
      .cur_low  (cur_low),
      .step_low (step_low)
   );

   // Write is clocked into the array on the clk edge that ends the capture cycle
   sbsc_mem u_mem (
      .clk     (clk),
      .addr    (mem_addr),
      .we_mask (wmask),
      .wdata   (dq_in),
      .rd_en   (rd),
      .rdata   (mem_rdata)
   );

   // Read pipeline and deselect tracking
   always_ff @(posedge clk) begin
      if (!nrst) begin
         rd_v1    <= 1'b0;
         rd_v2    <= 1'b0;
         desel_v1 <= 1'b0;
      end else begin
         rd_v1    <= rd;
         rd_v2    <= rd_v1;
         desel_v1 <= desel;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         pipe_data <= '0;
      end else if (rd_v1) begin
         pipe_data <= mem_rdata;
      end
   end

   // Single deselect cuts the pending read one stage early
   always_comb begin
      if (!pipelined) begin
         next_dq_en = rd;
      end else if (two_cycle_deselect) begin
         next_dq_en = rd_v1;
      end else begin
         next_dq_en = rd_v1 && !desel;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         dq_en <= 1'b0;
      end else begin
         dq_en <= next_dq_en;
      end
   end

   // Static mode pin chooses the source; no glitch in use
   always_comb begin
      dq_out = pipelined ? pipe_data : mem_rdata;
   end

   // Output enable and sleep reach the drivers unclocked
   always_comb begin
      dq_oe = dq_en && !out_en_n && !sleep_req;
   end

   // Parity checked on what the pins present, even or odd
   always_ff @(posedge clk) begin
      if (!nrst) begin
         parity_err <= '0;
      end else begin
         for (int i = 0; i < `SBSC_LANES; i++) begin
            parity_err[i] <= dq_en && !ninth_bit_en_n &&
               ((^dq_out[i*`SBSC_LANE_W +: `SBSC_LANE_W]) ^ parity_odd);
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         asleep <= 1'b0;
      end else begin
         asleep <= sleep_req;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   load_start_a: assert property (
      load |=> (state == SBSC_BURST) && (addr_hi == $past(addr[`SBSC_AW-1:2])))
      else $error("strobe did not start a burst");

   desel_idle_a: assert property (
      desel |=> (state == SBSC_IDLE))
      else $error("deselect left the burst active");

   hold_count_a: assert property (
      (cont && burst_step_n) |=> (cur_low == $past(cur_low)))
      else $error("counter moved without advance");

   step_count_a: assert property (
      step |=> (cur_low == $past(step_low)))
      else $error("counter missed an advance");

   flow_lat_a: assert property (
      (rd && !pipelined) |=> dq_en && (dq_out == mem_rdata))
      else $error("flow-through read not shown next cycle");

   pipe_lat_a: assert property (
      (rd && pipelined && two_cycle_deselect) |-> ##2 (dq_en && (dq_out == $past(mem_rdata))))
      else $error("pipelined read not shown after two edges");

   scd_cut_a: assert property (
      (pipelined && !two_cycle_deselect && desel) |=> !dq_en)
      else $error("single deselect did not cut outputs");

   dcd_hold_a: assert property (
      (pipelined && two_cycle_deselect && rd_v1 && desel) |=> dq_en)
      else $error("dual deselect cut outputs too early");

   gw_all_a: assert property (
      (access && !all_write_n) |-> (wmask == '1))
      else $error("global write missed a lane");

   bw_lane_a: assert property (
      (access && all_write_n && !lane_write_n) |-> (wmask == ~lane_enable_n))
      else $error("byte write lanes wrong");

   oe_gate_a: assert property (
      dq_oe |-> (dq_en && !out_en_n && !sleep_req))
      else $error("data driven while not allowed");

   sleep_block_a: assert property (
      sleep_req |-> (!access && (wmask == '0)))
      else $error("access taken while asleep");

   pins_default_a: assert property (
      (mode_driven == 3'h0) |-> (pipelined && !linear && !two_cycle_deselect))
      else $error("floating mode pins not defaulted");

   // Address path and burst bookkeeping
   load_addr_a: assert property (
      load |-> (mem_addr == addr))
      else $error("loaded address not used at once");

   burst_hi_a: assert property (
      cont |-> (mem_addr[`SBSC_AW-1:2] == addr_hi))
      else $error("burst left its group of four");

   hi_hold_a: assert property (
      !load |=> (addr_hi == $past(addr_hi)))
      else $error("burst base changed without a strobe");

   idle_nop_a: assert property (
      ((state == SBSC_IDLE) && !strobe) |-> !access)
      else $error("access without a strobe while idle");

   // Read path timing in both modes
   flow_off_a: assert property (
      (!pipelined && !rd) |=> !dq_en)
      else $error("flow-through output without a read");

   pipe_off_a: assert property (
      (pipelined && !rd_v1) |=> !dq_en)
      else $error("pipelined output without a read");

   pipe_hold_a: assert property (
      !rd_v1 |=> (pipe_data == $past(pipe_data)))
      else $error("output register changed without a read");

   pipe_depth_a: assert property (
      (pipelined && two_cycle_deselect && rd_v2) |-> dq_en)
      else $error("pipelined read lost in the pipeline");

   scd_show_a: assert property (
      (pipelined && !two_cycle_deselect && rd_v1 && !desel) |=> dq_en)
      else $error("single deselect dropped a live read");

   dcd_off_a: assert property (
      (pipelined && two_cycle_deselect && desel_v1) |=> !dq_en)
      else $error("dual deselect kept outputs on");

   // Write, sleep and parity housekeeping
   write_no_rd_a: assert property (
      (wmask != '0) |-> !rd)
      else $error("write cycle also produced read data");

   plain_read_a: assert property (
      (access && all_write_n && lane_write_n) |-> rd)
      else $error("cycle without write controls did not read");

   oe_async_a: assert property (
      (out_en_n || sleep_req) |-> !dq_oe)
      else $error("data driven against output enable or sleep");

   sleep_hold_a: assert property (
      sleep_req |=> (state == $past(state)))
      else $error("burst state moved while asleep");

   asleep_flag_a: assert property (
      1'b1 |=> (asleep == $past(sleep_req)))
      else $error("sleep status does not follow request");

   parity_off_a: assert property (
      ninth_bit_en_n |=> (parity_err == '0))
      else $error("parity error with checking disabled");

   parity_idle_a: assert property (
      !dq_en |=> (parity_err == '0))
      else $error("parity error without driven data");

   burst_read_c: cover property (load ##1 step [*3]);
   pipe_read_c: cover property (rd && pipelined ##2 dq_oe);
   flow_read_c: cover property (rd && !pipelined ##1 dq_oe);
   sleep_c: cover property ((state == SBSC_BURST && sleep_req) ##1 sleep_req ##1 !sleep_req);
   dcd_hold_c: cover property (pipelined && two_cycle_deselect && rd_v1 && desel);
endmodule
`default_nettype wire

// ==== verilog/sbsc_defines.svh ====
// Constants for the synchronous burst static memory core
`ifndef SBSC_DEFINES_SVH
`define SBSC_DEFINES_SVH

`define SBSC_X36      0
`define SBSC_DW       ((`SBSC_X36) ? 36 : 18)
`define SBSC_AW       ((`SBSC_X36) ? 18 : 19)
`define SBSC_DEPTH    ((`SBSC_X36) ? 262144 : 524288)
`define SBSC_LANES    ((`SBSC_X36) ? 4 : 2)
`define SBSC_LANE_W   9
`define SBSC_BURST_W  2
`define SBSC_MD_BYPASS  0
`define SBSC_MD_ORDER   1
`define SBSC_MD_DESEL   2

`endif

// ==== verilog/sbsc_mem.sv ====
// Storage array with lane write mask and registered read data
`timescale 1ns/1ps
`default_nettype none
`include "sbsc_defines.svh"
module sbsc_mem
   import sbsc_pkg::*;
(
   input  wire logic                   clk,
   input  wire logic [`SBSC_AW-1:0]    addr,
   input  wire logic [`SBSC_LANES-1:0] we_mask,
   input  wire logic [`SBSC_DW-1:0]    wdata,
   input  wire logic                   rd_en,
   output var  logic [`SBSC_DW-1:0]    rdata
);
   logic [`SBSC_DW-1:0] mem [0:`SBSC_DEPTH-1];

   // No reset on the array so contents survive anything
   always_ff @(posedge clk) begin
      for (int i = 0; i < `SBSC_LANES; i++) begin
         if (we_mask[i]) begin
            mem[addr][i*`SBSC_LANE_W +: `SBSC_LANE_W] <=
               wdata[i*`SBSC_LANE_W +: `SBSC_LANE_W];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rd_en) begin
         rdata <= mem[addr];
      end
   end
endmodule
`default_nettype wire

// ==== verilog/sbsc_pkg.sv ====
// Types and the shared burst sequence function for the burst memory core
`include "sbsc_defines.svh"
package sbsc_pkg;
   typedef enum logic {SBSC_IDLE, SBSC_BURST} sbsc_state_t;
   typedef logic [`SBSC_BURST_W-1:0] sbsc_low_t;

   // Burst sequence position from start and count
   function automatic sbsc_low_t sbsc_seq(input sbsc_low_t start,
                                          input sbsc_low_t cnt,
                                          input logic      linear);
      sbsc_low_t r;
      r = linear ? sbsc_low_t'(start + cnt) : (start ^ cnt);
      return r;
   endfunction
endpackage
